// file: tft_pkg.sv
// Constants for the tamper flag and phase trim block.
// Assumes one 100 MHz clock and a line period tick from the metering core.
package tft_pkg;
  localparam int          CLK_NS          = 10;
  localparam int          LINE_HZ         = 50;
  localparam int          CNT_W           = 6;
  localparam logic [5:0]  SW_NORMAL       = 6'h20;
  localparam logic [5:0]  SW_TAMP_P       = 6'h3C;
  localparam logic [5:0]  SW_TAMP_S       = 6'h04;
  localparam logic [5:0]  WIN_HALF        = 6'h04;
  localparam logic [2:0]  CONFIRM_N       = 3'h4;
  localparam int          EN_W            = 24;
  localparam int          SUM_W           = 26;
  localparam int          SMP_W           = 16;
  localparam int          PH_W            = 4;
  localparam logic [3:0]  PH_RST          = 4'h0;
  localparam int          PH_STEP_MDEG    = 38;
  localparam int          PH_MAX_MDEG     = 576;
  localparam int          PH_STEP_NS      = (PH_STEP_MDEG * 1000000) / (360 * LINE_HZ);
  localparam int          PH_STEP_CYC     = (PH_STEP_NS / CLK_NS < 1) ? 1 : PH_STEP_NS / CLK_NS;
  localparam logic [7:0]  PH_STEP_LAST    = 8'(PH_STEP_CYC - 1);
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_TAMP_P = 2'b01,
    ST_TAMP_S = 2'b10
  } tft_state_t;
  typedef enum logic [1:0] {
    RES_NORMAL = 2'b00,
    RES_A_HI   = 2'b01,
    RES_B_HI   = 2'b10
  } tft_res_t;
endpackage

// file: tft_dly_mem.sv
// Small delay memory for the phase trim path, registered read port.
// Assumes writes and reads share the main clock and clock enable.
`timescale 1ns/1ps
module tft_dly_mem
  import tft_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic             we_i,
  input  wire logic [PH_W-1:0]  waddr_i,
  input  wire logic [SMP_W-1:0] wdata_i,
  input  wire logic             re_i,
  input  wire logic [PH_W-1:0]  raddr_i,
  output logic      [SMP_W-1:0] rdata_o
);
  logic [SMP_W-1:0] mem_r [16];
  logic [SMP_W-1:0] rdata_nxt;

  // Write-first bypass so a zero trim reads the sample just written
  always_comb begin
    rdata_nxt = rdata_o;
    if (re_i) begin
      rdata_nxt = (we_i && (waddr_i == raddr_i)) ? wdata_i : mem_r[raddr_i];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i && we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else if (clk_en_i) begin
      rdata_o <= rdata_nxt;
    end
  end
endmodule

// file: tft_core.sv
// Tamper state machine, tamper flag, serial pin mux and phase trim delay.
// Assumes line_tick_i pulses once per line period and inputs are synchronous.
`timescale 1ns/1ps
module tft_core
  import tft_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic             line_tick_i,
  input  wire logic             period_ok_i,
  input  wire logic             mod_v_stuck_i,
  input  wire logic             mod_i_stuck_i,
  input  wire logic             no_load_i,
  input  wire logic [EN_W-1:0]  prim_energy_i,
  input  wire logic [EN_W-1:0]  sec_energy_i,
  input  wire logic             standalone_i,
  input  wire logic             spi_data_i,
  input  wire logic             phase_code_we_i,
  input  wire logic [PH_W-1:0]  phase_code_wdata_i,
  input  wire logic [SMP_W-1:0] v_sample_i,
  input  wire logic [SMP_W-1:0] i_sample_i,
  output logic                  tamper_flag_o,
  output logic                  serial_data_pin_o,
  output logic                  samp_active_o,
  output logic                  use_sec_o,
  output logic      [EN_W-1:0]  energy_o,
  output logic                  energy_valid_o,
  output logic      [PH_W-1:0]  phase_delay_code_o,
  output logic      [SMP_W-1:0] v_out_o,
  output logic      [SMP_W-1:0] i_out_o,
  output logic                  out_valid_o
);
  tft_state_t       state_r, state_nxt;
  tft_res_t         cand_r, cand_nxt, res;
  logic [CNT_W-1:0] per_r, per_nxt;
  logic [2:0]       hits_r, hits_nxt;
  logic [SUM_W-1:0] sum_a_r, sum_a_nxt, sum_b_r, sum_b_nxt;
  logic [EN_W-1:0]  hold_r, hold_nxt, energy_nxt;
  logic             flag_nxt, pin_nxt, samp_nxt, sec_nxt, ev_nxt, bad;
  logic [5:0]       sw;

  function automatic logic [5:0] switch_point(input tft_state_t s);
    unique case (s)
      ST_TAMP_P: switch_point = SW_TAMP_P;
      ST_TAMP_S: switch_point = SW_TAMP_S;
      default:   switch_point = SW_NORMAL;
    endcase
  endfunction

  function automatic logic in_window(input logic [5:0] cnt, input tft_state_t s);
    logic [5:0] p;
    p = switch_point(s);
    // One bit wider so the window that closes at 64 does not wrap to zero
    in_window = ({1'b0, cnt} >= {1'b0, p} - {1'b0, WIN_HALF}) &&
                ({1'b0, cnt} < {1'b0, p} + {1'b0, WIN_HALF});
  endfunction

  function automatic tft_state_t res_state(input tft_res_t r);
    unique case (r)
      RES_A_HI: res_state = ST_TAMP_P;
      RES_B_HI: res_state = ST_TAMP_S;
      default:  res_state = ST_NORMAL;
    endcase
  endfunction

  // A channel counts as much higher when it beats the other by an eighth
  always_comb begin
    logic [SUM_W-1:0] a;
    logic [SUM_W-1:0] b;
    a   = sum_a_r + ((per_r < sw) ? SUM_W'(prim_energy_i) : '0);
    b   = sum_b_r + ((per_r >= sw) ? SUM_W'(sec_energy_i) : '0);
    res = RES_NORMAL;
    if ({1'b0, a} > {1'b0, b} + 27'(b >> 3)) begin
      res = RES_A_HI;
    end else if ({1'b0, b} > {1'b0, a} + 27'(a >> 3)) begin
      res = RES_B_HI;
    end
  end

  always_comb begin
    sw         = switch_point(state_r);
    bad        = !period_ok_i || mod_v_stuck_i || mod_i_stuck_i || no_load_i;
    state_nxt  = state_r;
    cand_nxt   = cand_r;
    hits_nxt   = hits_r;
    per_nxt    = per_r;
    sum_a_nxt  = sum_a_r;
    sum_b_nxt  = sum_b_r;
    hold_nxt   = hold_r;
    energy_nxt = energy_o;
    ev_nxt     = 1'b0;
    if (line_tick_i) begin
      per_nxt = per_r + 6'h01;
      ev_nxt  = 1'b1;
      unique case (state_r)
        ST_NORMAL: energy_nxt = (per_r < sw) ? prim_energy_i : sec_energy_i;
        ST_TAMP_P: begin
          energy_nxt = (per_r < sw) ? prim_energy_i : hold_r;
          if (per_r < sw) begin
            hold_nxt = prim_energy_i;
          end
        end
        ST_TAMP_S: begin
          energy_nxt = (per_r >= sw) ? sec_energy_i : hold_r;
          if (per_r >= sw) begin
            hold_nxt = sec_energy_i;
          end
        end
        default: state_nxt = ST_NORMAL;
      endcase
      if (in_window(per_r, state_r)) begin
        if (per_r < sw) begin
          sum_a_nxt = sum_a_r + SUM_W'(prim_energy_i);
        end else begin
          sum_b_nxt = sum_b_r + SUM_W'(sec_energy_i);
        end
      end
      if (per_r == sw + WIN_HALF - 6'h01) begin
        sum_a_nxt = '0;
        sum_b_nxt = '0;
        if (res_state(res) == state_r) begin
          hits_nxt = 3'h0;
        end else if (res == cand_r && hits_r != 3'h0) begin
          hits_nxt = hits_r + 3'h1;
        end else begin
          cand_nxt = res;
          hits_nxt = 3'h1;
        end
        if (hits_nxt == CONFIRM_N) begin
          state_nxt = res_state(res);
          hits_nxt  = 3'h0;
          per_nxt   = '0;
        end
      end
    end
    if (bad) begin
      state_nxt = ST_NORMAL;
      cand_nxt  = RES_NORMAL;
      hits_nxt  = 3'h0;
      sum_a_nxt = '0;
      sum_b_nxt = '0;
    end
    flag_nxt = (state_nxt != ST_NORMAL);
    pin_nxt  = standalone_i ? flag_nxt : spi_data_i;
    samp_nxt = in_window(per_nxt, state_nxt) && !bad;
    sec_nxt  = (state_nxt == ST_TAMP_S) ||
               ((state_nxt == ST_NORMAL) && (per_nxt >= switch_point(state_nxt)));
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r           <= ST_NORMAL;
      cand_r            <= RES_NORMAL;
      hits_r            <= 3'h0;
      per_r             <= '0;
      sum_a_r           <= '0;
      sum_b_r           <= '0;
      hold_r            <= '0;
      energy_o          <= '0;
      energy_valid_o    <= 1'b0;
      tamper_flag_o     <= 1'b0;
      serial_data_pin_o <= 1'b0;
      samp_active_o     <= 1'b0;
      use_sec_o         <= 1'b0;
    end else if (clk_en_i) begin
      state_r           <= state_nxt;
      cand_r            <= cand_nxt;
      hits_r            <= hits_nxt;
      per_r             <= per_nxt;
      sum_a_r           <= sum_a_nxt;
      sum_b_r           <= sum_b_nxt;
      hold_r            <= hold_nxt;
      energy_o          <= energy_nxt;
      energy_valid_o    <= ev_nxt;
      tamper_flag_o     <= flag_nxt;
      serial_data_pin_o <= pin_nxt;
      samp_active_o     <= samp_nxt;
      use_sec_o         <= sec_nxt;
    end
  end

  // Phase trim: voltage path delayed by code whole steps, current path by none
  logic [7:0]      step_r, step_nxt;
  logic [PH_W-1:0] wptr_r, wptr_nxt, code_nxt;
  logic [SMP_W-1:0] i_nxt;
  logic            step_tick, ov_nxt;

  always_comb begin
    step_tick = (step_r == PH_STEP_LAST);
    step_nxt  = step_tick ? 8'h00 : step_r + 8'h01;
    wptr_nxt  = step_tick ? wptr_r + 4'h1 : wptr_r;
    code_nxt  = phase_code_we_i ? phase_code_wdata_i : phase_delay_code_o;
    i_nxt     = step_tick ? i_sample_i : i_out_o;
    ov_nxt    = step_tick;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      step_r             <= 8'h00;
      wptr_r             <= '0;
      phase_delay_code_o <= PH_RST;
      i_out_o            <= '0;
      out_valid_o        <= 1'b0;
    end else if (clk_en_i) begin
      step_r             <= step_nxt;
      wptr_r             <= wptr_nxt;
      phase_delay_code_o <= code_nxt;
      i_out_o            <= i_nxt;
      out_valid_o        <= ov_nxt;
    end
  end

  // Read lags write by the code, so the shift is linear in whole steps
  tft_dly_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .clk_en_i  (clk_en_i),
    .we_i      (step_tick),
    .waddr_i   (wptr_r),
    .wdata_i   (v_sample_i),
    .re_i      (step_tick),
    .raddr_i   (wptr_r - phase_delay_code_o),
    .rdata_o   (v_out_o)
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_bad;
    clk_en_i && (!period_ok_i || mod_v_stuck_i || mod_i_stuck_i || no_load_i);
  endsequence

  a_flag_state:    assert property (tamper_flag_o == (state_r != ST_NORMAL))
    else $error("flag disagrees with state");
  a_pin_standalone: assert property (clk_en_i && standalone_i |=> serial_data_pin_o == tamper_flag_o)
    else $error("serial pin does not show flag");
  a_bad_normal:    assert property (s_bad |=> state_r == ST_NORMAL && !tamper_flag_o && hits_r == 3'h0)
    else $error("tamper not forced normal");
  a_zero_trim:     assert property (clk_en_i && step_tick && phase_delay_code_o == 4'h0
                                    |=> v_out_o == $past(v_sample_i) && i_out_o == $past(i_sample_i))
    else $error("zero code shifts paths");
  a_code_write:    assert property (clk_en_i && phase_code_we_i |=> phase_delay_code_o == $past(phase_code_wdata_i))
    else $error("code write lost");
  a_step_period:   assert property (clk_en_i && step_tick |=> !step_tick)
    else $error("step tick too frequent");
  a_normal_mux:    assert property (clk_en_i && line_tick_i && state_r == ST_NORMAL && !bad
                                    |=> energy_o == (($past(per_r) < SW_NORMAL) ? $past(prim_energy_i)
                                                                                 : $past(sec_energy_i)))
    else $error("normal channel mux wrong");
  a_win_normal:    assert property (state_r == ST_NORMAL && !bad && per_r == 6'h1C && clk_en_i |=> samp_active_o)
    else $error("sampling window not open");
  a_confirm_four:  assert property (clk_en_i && state_r == ST_NORMAL && state_nxt != ST_NORMAL
                                    |-> hits_r == CONFIRM_N - 3'h1)
    else $error("tamper entered early");
  a_tamp_sel:      assert property (state_r == ST_TAMP_S |-> use_sec_o)
    else $error("secondary not selected");
endmodule

// file: tft_core_tb.sv
// Self-checking bench for tft_core: tamper states, serial pin and phase trim.
// Assumes the internal step tick of the core; the bench drives every port itself.
`timescale 1ns/1ps
module tft_core_tb;
  import tft_pkg::*;
  logic             sys_clk_i = 1'b0;
  logic             arst_n_i  = 1'b0;
  logic             tick      = 1'b0;
  logic             ok        = 1'b1;
  logic             vst       = 1'b0;
  logic             ist       = 1'b0;
  logic             nl        = 1'b0;
  logic [EN_W-1:0]  prim      = 24'h000100;
  logic [EN_W-1:0]  sec       = 24'h0000F8;
  logic             alone     = 1'b1;
  logic             spi       = 1'b0;
  logic             en        = 1'b1;
  logic             we        = 1'b0;
  logic [PH_W-1:0]  wd        = 4'h0;
  logic [SMP_W-1:0] v_s       = 16'h0000;
  logic [SMP_W-1:0] i_s       = 16'h0000;
  logic             flag, pin, samp, use_sec, e_vld, o_vld;
  logic [EN_W-1:0]  energy;
  logic [PH_W-1:0]  code;
  logic [SMP_W-1:0] v_out, i_out;
  int               error_cnt = 0;
  int               compares  = 0;
  int               n0, n3, n15, ni, nt;

  always #5 sys_clk_i = ~sys_clk_i;

  tft_core u_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(en), .line_tick_i(tick),
    .period_ok_i(ok), .mod_v_stuck_i(vst), .mod_i_stuck_i(ist), .no_load_i(nl), .prim_energy_i(prim),
    .sec_energy_i(sec), .standalone_i(alone), .spi_data_i(spi), .phase_code_we_i(we),
    .phase_code_wdata_i(wd), .v_sample_i(v_s), .i_sample_i(i_s), .tamper_flag_o(flag),
    .serial_data_pin_o(pin), .samp_active_o(samp), .use_sec_o(use_sec), .energy_o(energy),
    .energy_valid_o(e_vld), .phase_delay_code_o(code), .v_out_o(v_out), .i_out_o(i_out),
    .out_valid_o(o_vld));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Ticks four cycles apart, so status has settled before the next one
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      tick <= 1'b1;
      @(posedge sys_clk_i);
      tick <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
    end
    @(negedge sys_clk_i);
  endtask

  task automatic wait_step;
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (o_vld !== 1'b1 && n < 300);
    if (n >= 300) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic wr_code(input logic [3:0] c);
    @(posedge sys_clk_i);
    we <= 1'b1;
    wd <= c;
    @(posedge sys_clk_i);
    we <= 1'b0;
    @(negedge sys_clk_i);
    chk("phase_delay_code_o", 24'(c), 24'(code));
  endtask

  // Steps from a sample change until it shows on each path
  task automatic trim_lat(input logic [3:0] c, input logic [15:0] nv, output int n);
    wr_code(c);
    repeat (17) wait_step();
    @(posedge sys_clk_i);
    v_s <= nv;
    i_s <= ~nv;
    n = 0;
    ni = 0;
    while (v_out !== nv && n < 40) begin
      wait_step();
      n++;
      if (i_out === ~nv && ni == 0) ni = n;
    end
    chk("i_out_o steps", 24'h1, 24'(ni));
  endtask

  task automatic until_flag(output int n);
    n = 0;
    while (flag !== 1'b1 && n < 400) begin
      ticks(1);
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic t_reset;
    chk("tamper_flag_o", 24'h0, 24'(flag));
    chk("phase_delay_code_o", 24'h0, 24'(code));
  endtask

  task automatic t_trim;
    trim_lat(4'h0, 16'hA5C3, n0);
    trim_lat(4'h3, 16'h5A3C, n3);
    trim_lat(4'hF, 16'hC35A, n15);
    chk("v_out_o code 0 steps", 24'(ni), 24'(n0));
    chk("v_out_o code 3 extra", 24'h3, 24'(n3 - n0));
    chk("v_out_o code 15 extra", 24'hF, 24'(n15 - n0));
  endtask

  task automatic t_normal;
    ticks(10);
    chk("use_sec_o p10", 24'h0, 24'(use_sec));
    chk("energy_o p10", prim, energy);
    @(posedge sys_clk_i);
    tick <= 1'b1;
    @(posedge sys_clk_i);
    tick <= 1'b0;
    @(negedge sys_clk_i);
    chk("energy_valid_o pulse", 24'h1, 24'(e_vld));
    @(negedge sys_clk_i);
    chk("energy_valid_o drop", 24'h0, 24'(e_vld));
    ticks(19);
    chk("samp_active_o p30", 24'h1, 24'(samp));
    ticks(10);
    chk("use_sec_o p40", 24'h1, 24'(use_sec));
    chk("samp_active_o p40", 24'h0, 24'(samp));
    chk("energy_o p40", sec, energy);
  endtask

  // Everything must hold still while the enable is low, even a tick and a write
  task automatic t_freeze;
    logic [EN_W-1:0] e0;
    logic [PH_W-1:0] c0;
    e0 = energy;
    c0 = code;
    @(posedge sys_clk_i);
    en   <= 1'b0;
    tick <= 1'b1;
    we   <= 1'b1;
    wd   <= ~c0;
    @(posedge sys_clk_i);
    tick <= 1'b0;
    we   <= 1'b0;
    repeat (250) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("phase_delay_code_o frozen", 24'(c0), 24'(code));
    chk("energy_o frozen", e0, energy);
    chk("energy_valid_o frozen", 24'h0, 24'(e_vld));
    @(posedge sys_clk_i);
    en <= 1'b1;
  endtask

  task automatic t_tamper;
    @(posedge sys_clk_i);
    prim <= 24'h001000;
    sec  <= 24'h000100;
    until_flag(nt);
    chk("ticks to tamper", 24'd252, 24'(nt));
    repeat (2) @(negedge sys_clk_i);
    chk("serial_data_pin_o alone", 24'h1, 24'(pin));
    @(posedge sys_clk_i);
    alone <= 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk("serial_data_pin_o spi 0", 24'h0, 24'(pin));
    @(posedge sys_clk_i);
    spi <= 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("serial_data_pin_o spi 1", 24'h1, 24'(pin));
    ticks(30);
    chk("use_sec_o t30", 24'h0, 24'(use_sec));
    ticks(32);
    chk("use_sec_o t62", 24'h0, 24'(use_sec));
    chk("energy_o t62 gap", prim, energy);
    chk("samp_active_o t62", 24'h1, 24'(samp));
    ticks(2);
    chk("use_sec_o t64", 24'h0, 24'(use_sec));
  endtask

  task automatic t_bad;
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      ok  <= (k != 0);
      vst <= (k == 1);
      ist <= (k == 2);
      nl  <= (k == 3);
      repeat (3) @(negedge sys_clk_i);
      chk("tamper_flag_o forced", 24'h0, 24'(flag));
      chk("samp_active_o forced", 24'h0, 24'(samp));
      @(posedge sys_clk_i);
      ok  <= 1'b1;
      vst <= 1'b0;
      ist <= 1'b0;
      nl  <= 1'b0;
      if (k < 3) until_flag(nt);
    end
  endtask

  // Secondary much higher: tamper toward the secondary, gap holds its energy
  task automatic t_tamp_s;
    @(posedge sys_clk_i);
    prim <= 24'h000100;
    sec  <= 24'h001000;
    until_flag(nt);
    chk("use_sec_o s0", 24'h1, 24'(use_sec));
    chk("samp_active_o s0", 24'h1, 24'(samp));
    ticks(66);
    chk("use_sec_o s2", 24'h1, 24'(use_sec));
    chk("energy_o s2 gap", sec, energy);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    t_reset();
    t_trim();
    t_normal();
    t_freeze();
    t_tamper();
    t_bad();
    t_tamp_s();
    report_and_stop();
  end
endmodule
